// ### rtl/besl_pkg.sv
// Purpose: constants for the bus error status logger
// Assumes: apb slave, 32-bit data, 64-bit status split over two words
// Notes:   field positions follow the status layout
package besl_pkg;
  localparam logic [7:0]  ADDR_STATUS_LO = 8'h00;
  localparam logic [7:0]  ADDR_STATUS_HI = 8'h04;
  localparam logic [7:0]  ADDR_CTRL      = 8'h08;
  localparam logic [7:0]  ADDR_SIG       = 8'h0C;
  // arbitrary signature that enables the interrupt-controller-space check
  localparam logic [31:0] SIG_MATCH      = 32'h0000A5A5;
  localparam int BIT_ADDR_PAR  = 16;
  localparam int BIT_RSP_FAIL  = 17;
  localparam int BIT_RSP_PAR   = 18;
  localparam int BIT_DATA_PAR  = 19;
  localparam int BIT_ICS_WB    = 20;
  localparam int BIT_PAD_SM    = 21;
  localparam int BIT_DSTB      = 22;
  localparam int BIT_ASTB      = 23;
  localparam int BIT_EN        = 60;
  localparam int BIT_UC        = 61;
  localparam int BIT_OVER      = 62;
  localparam int BIT_VAL       = 63;
  localparam int NUM_FLAGS     = 8;
  localparam logic [4:0]  BUS_CODE_HEAD   = 5'h01;
  localparam logic [7:0]  CACHE_CODE_HEAD = 8'h01;
  localparam logic [63:0] STATUS_RESET    = 64'h0;
  localparam logic [63:0] STATUS_KEEP_MASK = 64'hFE00_0000_00FF_FFFF;
endpackage

// ### rtl/besl_logger.sv
// Purpose: log system bus and cache errors into a 64-bit bank status register
// Assumes: error pulses synchronous to i_clk_sys; apb master keeps protocol
// Notes:   software clears by writing zero to the status words
//
// The implementer's own choices: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps

// Notes on behaviour
// RQ1: bus errors give code 00001PPTRRRRIILL in 0-15
// RQ2: bit 16 marks address parity error
// RQ3: bit 17 marks response hard failure
// RQ4: bit 18 marks response parity error
// RQ5: bit 19 marks data parity error
// RQ6: bit 20 only with matching signature
// RQ7: bit 22 marks data strobe glitch
// RQ8: bit 23 marks address strobe glitch
// RQ9: cache errors give code 00000001RRRRTTLL
// RQ10: overflow set on error while valid
// RQ11: valid set on every log, software clears
// RQ12: overwrite priority, never replace valid uncorrected
// RQ13: code and flags together, reserved zero
module besl_logger
  import besl_pkg::*;
(
  input  wire logic        i_clk_sys,    // 250 MHz clock
  input  wire logic        i_reset,      // sync reset, high
  input  wire logic        i_ce,         // clock enable
  input  wire logic        i_bus_err,    // bus error event pulse
  input  wire logic [1:0]  i_bus_pp,     // participation
  input  wire logic        i_bus_t,      // timeout
  input  wire logic [3:0]  i_bus_rrrr,   // request
  input  wire logic [1:0]  i_bus_ii,     // memory or io
  input  wire logic [1:0]  i_bus_ll,     // level
  input  wire logic [NUM_FLAGS-1:0] i_flags, // bits 16..23 detail flags
  input  wire logic        i_cache_err,  // cache error event pulse
  input  wire logic [3:0]  i_cache_rrrr, // request
  input  wire logic [1:0]  i_cache_tt,   // transaction type
  input  wire logic [1:0]  i_cache_ll,   // level
  input  wire logic        i_err_uc,     // error uncorrected
  input  wire logic        i_err_en,     // error reporting enabled
  input  wire logic        i_psel,       // apb select
  input  wire logic        i_penable,    // apb enable
  input  wire logic        i_pwrite,     // apb write
  input  wire logic [7:0]  i_paddr,      // apb address
  input  wire logic [31:0] i_pwdata,     // apb write data
  output logic [31:0]      o_prdata,     // apb read data
  output logic             o_pready,     // apb ready
  output logic             o_pslverr,    // apb error
  output logic             o_valid       // entry valid flag
);
  logic [63:0] status_reg;
  logic [63:0] status_next;
  logic [31:0] sig_reg;
  logic [31:0] prdata_reg;
  logic        pready_reg;
  logic        pslverr_reg;

  wire sig_ok    = (sig_reg == SIG_MATCH);
  wire [NUM_FLAGS-1:0] flag_mask;
  genvar g;
  generate
    for (g = 0; g < NUM_FLAGS; g++) begin : g_flag
      if (g + BIT_ADDR_PAR == BIT_ICS_WB) begin : g_ics
        assign flag_mask[g] = sig_ok; // RQ6
      end else begin : g_plain
        assign flag_mask[g] = 1'b1; // RQ2 RQ3 RQ4 RQ5 RQ7 RQ8
      end
    end
  endgenerate

  wire any_err   = i_bus_err | i_cache_err;
  wire [15:0] bus_code   = {BUS_CODE_HEAD, i_bus_pp, i_bus_t, i_bus_rrrr,
                            i_bus_ii, i_bus_ll}; // RQ1
  wire [15:0] cache_code = {CACHE_CODE_HEAD, i_cache_rrrr, i_cache_tt,
                            i_cache_ll}; // RQ9
  wire [15:0] new_code   = i_bus_err ? bus_code : cache_code;
  wire [7:0]  new_flags  = i_bus_err ? (i_flags & flag_mask) : 8'h00;

  wire old_val = status_reg[BIT_VAL];
  wire old_uc  = status_reg[BIT_UC];
  wire old_en  = status_reg[BIT_EN];
  // a valid uncorrected entry is never replaced
  // corrected entries give way unless a disabled corrected error would replace an enabled one
  wire may_over = !old_val ||
                  (!old_uc && (i_err_uc || i_err_en || !old_en)); // RQ12

  wire apb_acc  = i_psel & i_penable & pready_reg;
  wire apb_wr   = apb_acc & i_pwrite;
  wire hit_lo   = (i_paddr == ADDR_STATUS_LO);
  wire hit_hi   = (i_paddr == ADDR_STATUS_HI);
  wire hit_sig  = (i_paddr == ADDR_SIG);
  wire hit_ctrl = (i_paddr == ADDR_CTRL);
  wire hit_any  = hit_lo | hit_hi | hit_sig | hit_ctrl;

  wire [63:0] sw_status = hit_lo ? {status_reg[63:32], i_pwdata} :
                                   {i_pwdata, status_reg[31:0]};
  wire [63:0] base = (apb_wr && (hit_lo || hit_hi)) ?
                     (sw_status & STATUS_KEEP_MASK) : status_reg; // RQ10 RQ11
  wire [63:0] logged = {1'b1, base[BIT_OVER] | old_val, i_err_uc, i_err_en,
                        4'h0, 32'h0, 8'h00, 16'h0};

  always_comb begin
    status_next = base;
    if (any_err) begin
      status_next[BIT_OVER] = base[BIT_OVER] | old_val; // RQ10
      status_next[BIT_VAL]  = 1'b1; // RQ11
      if (may_over) begin
        status_next = logged; // RQ13
        status_next[23:16] = new_flags; // RQ13
        status_next[15:0]  = new_code; // RQ13
      end
    end
  end

  wire [31:0] rd_mux = hit_lo  ? status_reg[31:0] :
                       hit_hi  ? status_reg[63:32] :
                       hit_sig ? sig_reg : 32'h0;

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      status_reg  <= STATUS_RESET;
      sig_reg     <= 32'h0;
      prdata_reg  <= 32'h0;
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
    end else if (i_ce) begin
      status_reg  <= status_next;
      if (apb_wr && hit_sig) begin
        sig_reg <= i_pwdata;
      end
      pready_reg  <= i_psel & i_penable & !pready_reg;
      pslverr_reg <= i_psel & i_penable & !pready_reg & !hit_any;
      prdata_reg  <= (i_psel & i_penable & !pready_reg) ? rd_mux : 32'h0;
    end
  end

  assign o_prdata  = prdata_reg;
  assign o_pready  = pready_reg;
  assign o_pslverr = pslverr_reg;
  assign o_valid   = status_reg[BIT_VAL];
endmodule

// ### sim/besl_agent.sv
// Purpose: far side that raises bus and cache error events
// Assumes: one request pulse per event
// Notes:   fields come straight from the bench
`timescale 1ns/1ps
module besl_agent (
  input  logic i_clk_sys, i_go, i_bus, // tick, request, kind
  output logic o_bus_err, o_cache_err  // one-cycle events
);
  // registered so each request gives exactly one one-cycle event
  always_ff @(posedge i_clk_sys) begin
    o_bus_err   <= i_go & i_bus;
    o_cache_err <= i_go & !i_bus;
  end
endmodule

// ### sim/besl_chk.sv
// Purpose: port checks of the status logger
// Assumes: one clock, sync reset
// Notes:   bound to every logger
`timescale 1ns/1ps
module besl_chk import besl_pkg::*; (
  input logic i_clk_sys, i_reset, i_ce, i_bus_err, i_cache_err, i_psel, i_penable,
  input logic i_pwrite, o_pready, o_pslverr, o_valid, // watched
  input logic [7:0] i_paddr, input logic [31:0] o_prdata // watched
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_reset);
  wire rd = o_pready & !i_pwrite & !o_pslverr;
  a_err_valid: assert property (i_ce & (i_bus_err | i_cache_err) |=> o_valid)
    else $error("valid not set");
  a_valid_kept: assert property ($fell(o_valid) |-> $past(i_pwrite & o_pready))
    else $error("valid lost");
  a_ready_wait: assert property (i_ce & i_psel & i_penable & !o_pready |=> o_pready)
    else $error("no ready");
  a_ready_pulse: assert property (o_pready |=> !o_pready) else $error("ready held");
  a_bad_addr: assert property (o_pready & (i_paddr > ADDR_SIG) |-> o_pslverr & !o_prdata)
    else $error("unmapped answered");
  a_hi_zero: assert property (rd & (i_paddr == ADDR_STATUS_HI) |-> !o_prdata[27:0])
    else $error("hi reserved set");
  a_lo_zero: assert property (rd & (i_paddr == ADDR_STATUS_LO) |-> !o_prdata[31:24])
    else $error("lo reserved set");
  a_hi_valid: assert property (rd & (i_paddr == ADDR_STATUS_HI) & $stable(o_valid)
    |-> o_prdata[31] == o_valid) else $error("valid bit differs");
  c_bus: cover property (i_bus_err);
  c_cache: cover property (i_cache_err);
  c_err: cover property (o_pslverr);
endmodule
bind besl_logger besl_chk u_chk (.*);

// ### sim/tb_top.sv
// Purpose: self-checking bench of the status logger
// Assumes: apb master, model of the status word
// Notes:   enable and clock enable driven by the bench
`timescale 1ns/1ps
module tb_top import besl_pkg::*; ;
  logic clk = 0, rst = 1, go = 0, kind = 0, uc = 0, psel = 0, pen = 0, pw = 0, slv, rdy, vld, be, ce;
  logic en = 1, cen = 1, sig = 0;
  logic [7:0] pa = 0, fl = 0;
  logic [15:0] rs = 16'h6C17;
  logic [31:0] pwd = 0, prd;
  logic [63:0] m = 0;
  int failures = 0, cmp_count = 0, cyc = 0;
  besl_logger dut (.i_clk_sys(clk), .i_reset(rst), .i_ce(cen), .i_bus_err(be),
    .i_bus_pp(rs[1:0]), .i_bus_t(rs[2]), .i_bus_rrrr(rs[6:3]), .i_bus_ii(rs[8:7]),
    .i_bus_ll(rs[10:9]), .i_flags(fl), .i_cache_err(ce), .i_cache_rrrr(rs[6:3]),
    .i_cache_tt(rs[8:7]), .i_cache_ll(rs[10:9]), .i_err_uc(uc), .i_err_en(en),
    .i_psel(psel), .i_penable(pen), .i_pwrite(pw), .i_paddr(pa), .i_pwdata(pwd),
    .o_prdata(prd), .o_pready(rdy), .o_pslverr(slv), .o_valid(vld));
  besl_agent u_agent (.i_clk_sys(clk), .i_go(go), .i_bus(kind), .o_bus_err(be), .o_cache_err(ce));
  initial forever #2 clk = ~clk;
  function automatic logic [15:0] lf(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic chk(input logic [31:0] s, e);
    cmp_count++;
    if (s !== e) begin
      failures++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic ap(input logic w, input logic [7:0] a, input logic [31:0] d, e);
    @(posedge clk);
    psel <= 1; pw <= w; pa <= a; pwd <= d;
    @(posedge clk) pen <= 1;
    do @(posedge clk); while (rdy !== 1'b1);
    psel <= 0; pen <= 0;
    chk({31'h0, slv}, {31'h0, a > ADDR_SIG});
    if (!w) chk(prd, e);
  endtask
  task automatic st();
    chk({31'h0, vld}, {31'h0, m[63]});
    ap(0, ADDR_STATUS_LO, 0, m[31:0]);
    ap(0, ADDR_STATUS_HI, 0, m[63:32]);
  endtask
  task automatic ev(input logic b, u, e, k);
    logic [15:0] n;
    logic [63:0] c;
    n = lf(rs);
    // flag 4 raised on every bus event: bit 20 survives only with a matching signature
    c = {2'h2, u, e, 36'h0,
         b ? {(n[15:8] | 8'h10) & (sig ? 8'hFF : 8'hEF), 5'h01, n[1:0], n[2]} : 16'h0001,
         n[6:3], n[8:7], n[10:9]};
    // k low: clock enable is held low while the pulse arrives, nothing logs
    if (k && !m[63]) m = c;
    else if (k && (m[61] || (!u && !e && m[60]))) m[62] = 1'b1;
    else if (k) m = c | 64'h4000_0000_0000_0000;
    @(posedge clk);
    rs <= n; fl <= b ? (n[15:8] | 8'h10) : 8'h00; uc <= u; en <= e; kind <= b; go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    cen <= k;
    @(posedge clk) cen <= 1'b1;
    @(posedge clk);
    st();
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      failures++;
      conclude();
    end
  end
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    st();
    ev(1, 0, 1, 1); ev(1, 1, 1, 1); ev(1, 0, 1, 1); ev(0, 1, 1, 1);
    ap(1, ADDR_STATUS_HI, 0, 0); ap(1, ADDR_STATUS_LO, 0, 0);
    m = 0;
    st();
    ev(0, 0, 1, 1); ev(1, 0, 1, 1); ev(1, 0, 0, 1); ev(1, 1, 0, 1);
    ap(1, ADDR_STATUS_HI, 0, 0); ap(1, ADDR_STATUS_LO, 0, 0);
    m = 0;
    ap(1, ADDR_SIG, SIG_MATCH, 0);
    sig = 1'b1;
    ap(0, ADDR_SIG, 0, SIG_MATCH);
    ap(0, ADDR_CTRL, 0, 0);
    ev(1, 0, 1, 0); ev(1, 0, 1, 1);
    ap(0, 8'h10, 0, 0);
    // second reset in mid-run: status and signature must return to zero
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    m = 0;
    sig = 1'b0;
    st();
    ap(0, ADDR_SIG, 0, 0);
    conclude();
  end
endmodule
